/* verilog/self_test_consts.svh */
`ifndef SELF_TEST_CONSTS_SVH
`define SELF_TEST_CONSTS_SVH
// Behaviour
// - At power-on the checks run by themselves, with no command needed.
// - Power-on checks run in a fixed order, then success or error is shown.
// - Work memory check failure shows no text and sounds the bell.
// - Screen memory check reports code 0, 1 or 2 on line 2.
// - Program store checksum mismatch is reported on line 4.
// - Keyboard check reports code 0 for link, 1 for interrupts, line 6.
// - Commands arrive as ESC [ 4 ; selector ; count y from keyboard or host.
// - Count sets repetitions; zero or omitted runs forever; above 256 means 255.
// - Selectors 20 to 26 each run one single test.
// - Selector 0 runs a combined set; 2, 3, 6, 7 run port tests.
// - Commanded tests blink a notice, show OK, or stop with an end notice.
// - Modem port loopback reports codes 0, 1, 2 on line 8.
// - Serial printer loopback reports codes 0 to 3 on line 10.
// - Current loop loopback reports codes 0, 1, 2 on line 16.
// - Printer fails on line 14 without ack in 10 s or busy clear in 60 s.
// - Control-line test drives each output on and off and checks line 12.
// - Control-line codes: 0/1 speed, 2/3 set-ready, 4/6 clear, 5/7 carrier.
// - Settings store mismatch is reported on line 2.
// - Display pattern test shows neither error nor success message.
`define REG_CMD 4'h0
`define REG_STATUS 4'h4
`define REG_LOOPS 4'h8
`define CLK_HZ 250000000
`define ACK_WAIT_S 10
`define BUSY_WAIT_S 60
`define BLINK_MS 500
`define STROBE_NS 1000
`define SETTLE_US 10
`define LINE_NONE 5'd0
`define LINE_RFM 5'd2
`define LINE_ROM 5'd4
`define LINE_KBD 5'd6
`define LINE_EIA 5'd8
`define LINE_SPR 5'd10
`define LINE_SIG 5'd12
`define LINE_PPR 5'd14
`define LINE_CLP 5'd16
`define LINE_SET 5'd2
`define MASK_POWERON 11'h00f
`define MASK_SEL0 11'h1fc
`define MASK_SEL1 11'h00e
`define MASK_DSP 11'h400
`define CNT_LIMIT 12'd256
`define CNT_CLAMP 9'd255
`define CH_ESC 8'h1b
`define CH_BRACKET 8'h5b
`define CH_FOUR 8'h34
`define CH_SEMI 8'h3b
`define CH_FINAL 8'h79
`define CH_ZERO 8'h30
`define PRT_MSG 32'h4f4b0d0a
`endif

/* verilog/self_test_pkg.sv */
package self_test_pkg;
  typedef enum logic [3:0] {
    T_RAM = 4'h0, T_RFM = 4'h1, T_ROM = 4'h2, T_KBD = 4'h3, T_EIA = 4'h4, T_SPR = 4'h5,
    T_SIG = 4'h6, T_PPR = 4'h7, T_CLP = 4'h8, T_SET = 4'h9, T_DSP = 4'ha
  } test_id_t;
  typedef enum logic [3:0] {
    SQ_IDLE = 4'h0, SQ_PICK = 4'h1, SQ_ENGINE = 4'h2, SQ_SIG = 4'h3,
    SQ_STB = 4'h4, SQ_ACK = 4'h5, SQ_BUSY = 4'h6
  } seq_state_t;
  typedef enum logic [2:0] {
    PR_IDLE = 3'h0, PR_ESC = 3'h1, PR_CSI = 3'h2, PR_FOUR = 3'h3, PR_SEL = 3'h4, PR_CNT = 3'h5
  } parse_state_t;
  typedef struct packed {logic start; test_id_t id;} engine_req_t;
  typedef struct packed {logic done; logic fail; logic [2:0] code;} engine_rsp_t;
  typedef struct packed {logic speedSel; logic termReady; logic reqSend;} modem_ctl_t;
  typedef struct packed {logic speedInd; logic setReady; logic clearSend; logic carrier;} modem_sense_t;
  typedef struct packed {logic strobe; logic [7:0] data;} printer_out_t;
  typedef struct packed {
    logic running; test_id_t test; logic [2:0] code; logic [4:0] line;
    logic showErr; logic showOk; logic showEnd; logic bell; logic blink;
  } display_status_t;
endpackage

/* verilog/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pinIn,
  output var logic [W-1:0] pinOut
);
  logic [W-1:0] stage_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage_reg <= '0;
      pinOut <= '0;
    end else begin
      stage_reg <= pinIn;
      pinOut <= stage_reg;
    end
  end
endmodule
`default_nettype wire

/* verilog/terminal_self_test_sequencer.sv */
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "self_test_consts.svh"
module terminal_self_test_sequencer #(
  parameter logic [33:0] ACK_CYC = 34'(64'(`ACK_WAIT_S) * 64'(`CLK_HZ)),
  parameter logic [33:0] BUSY_CYC = 34'(64'(`BUSY_WAIT_S) * 64'(`CLK_HZ)),
  parameter logic [33:0] BLINK_CYC = 34'(64'(`BLINK_MS) * 64'(`CLK_HZ) / 64'd1000)
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output var logic wready,
  output var logic [1:0] bresp,
  output var logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output var logic arready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  output var logic rvalid,
  input wire logic rready,
  input wire logic kbdValid,
  input wire logic [7:0] kbdByte,
  output var self_test_pkg::engine_req_t engineReq,
  input wire self_test_pkg::engine_rsp_t engineRsp,
  output var self_test_pkg::modem_ctl_t modemCtl,
  input wire self_test_pkg::modem_sense_t modemSense,
  output var self_test_pkg::printer_out_t printerOut,
  input wire logic printerAck,
  input wire logic printerBusy,
  output var self_test_pkg::display_status_t status
);
  import self_test_pkg::*;

  localparam logic [33:0] STB_CYC = 34'((`STROBE_NS * (`CLK_HZ / 1000000) + 999) / 1000);
  localparam logic [33:0] SETTLE_CYC = 34'(`SETTLE_US * (`CLK_HZ / 1000000));

  // ==========================================================
  // Pin inputs
  logic [5:0] pinsSync;
  pin_sync #(.W(6)) u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinIn({modemSense, printerAck, printerBusy}),
    .pinOut(pinsSync)
  );
  wire speedIndIn = pinsSync[5];
  wire dsr = pinsSync[4];
  wire cts = pinsSync[3];
  wire rlsd = pinsSync[2];
  wire ackIn = pinsSync[1];
  wire busyIn = pinsSync[0];

  // ==========================================================
  // Register bus
  logic awHeld_reg, wHeld_reg, hostPending_reg;
  logic [3:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic [7:0] hostByte_reg;
  wire awTake = awvalid & awready;
  wire wTake = wvalid & wready;
  wire [3:0] wrAddr = {awAddr_reg[3:2], 2'b00};
  wire [3:0] rdAddr = {araddr[3:2], 2'b00};
  wire wrCmd = wrAddr == `REG_CMD;
  wire wrMapped = wrCmd | (wrAddr == `REG_STATUS) | (wrAddr == `REG_LOOPS);
  wire doWrite = awHeld_reg & wHeld_reg & ~bvalid & ~(wrCmd & hostPending_reg);
  wire awHeld_next = (awHeld_reg | awTake) & ~doWrite;
  wire wHeld_next = (wHeld_reg | wTake) & ~doWrite;
  wire arTake = arvalid & arready;
  wire rvalid_next = (rvalid & ~rready) | arTake;
  wire hostTaken = hostPending_reg & ~kbdValid;
  wire rdMapped = (rdAddr == `REG_CMD) | (rdAddr == `REG_STATUS) | (rdAddr == `REG_LOOPS);

  logic [8:0] loops_reg;
  logic forever_reg, commanded_reg;
  logic [31:0] rdWord;
  always_comb begin
    rdWord = 32'h0;
    if (rdAddr == `REG_STATUS) begin
      rdWord = {12'h0, status.running, status.test, status.code, status.line, status.showErr,
                status.showOk, status.showEnd, commanded_reg, forever_reg, status.blink, 1'b0};
    end else if (rdAddr == `REG_LOOPS) begin
      rdWord = {22'h0, hostPending_reg, loops_reg};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0;
      hostPending_reg <= 1'b0;
      hostByte_reg <= 8'h0;
    end else begin
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awready <= ~awHeld_next;
      wready <= ~wHeld_next;
      if (awTake) awAddr_reg <= awaddr;
      if (wTake) wData_reg <= wdata;
      if (wTake) wStrb_reg <= wstrb;
      if (doWrite) bresp <= wrMapped ? 2'b00 : 2'b10;
      bvalid <= (bvalid & ~bready) | doWrite;
      arready <= ~rvalid_next;
      rvalid <= rvalid_next;
      if (arTake) rdata <= rdWord;
      if (arTake) rresp <= rdMapped ? 2'b00 : 2'b10;
      // A host byte written while one is still queued waits in the write path.
      if (doWrite && wrCmd && wStrb_reg[0]) begin
        hostByte_reg <= wData_reg[7:0];
        hostPending_reg <= 1'b1;
      end else if (hostTaken) begin
        hostPending_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Command parser
  parse_state_t parse_reg, parse_next;
  logic [7:0] selAcc_reg, selAcc_next;
  logic [11:0] cntAcc_reg, cntAcc_next;
  logic cmdIssue_reg, cmdIssue_next;
  wire chValid = kbdValid | hostPending_reg;
  wire [7:0] ch = kbdValid ? kbdByte : hostByte_reg;
  wire isDigit = (ch >= `CH_ZERO) && (ch <= `CH_ZERO + 8'd9);
  wire [7:0] digit = ch - `CH_ZERO;

  always_comb begin
    parse_next = parse_reg;
    selAcc_next = selAcc_reg;
    cntAcc_next = cntAcc_reg;
    cmdIssue_next = 1'b0;
    if (chValid) begin
      parse_next = (ch == `CH_ESC) ? PR_ESC : PR_IDLE;
      case (parse_reg)
        PR_ESC: if (ch == `CH_BRACKET) parse_next = PR_CSI;
        PR_CSI: if (ch == `CH_FOUR) parse_next = PR_FOUR;
        PR_FOUR: begin
          if (ch == `CH_SEMI) parse_next = PR_SEL;
          selAcc_next = 8'h0;
          cntAcc_next = 12'h0;
        end
        PR_SEL: begin
          if (isDigit) begin
            parse_next = PR_SEL;
            selAcc_next = (selAcc_reg > 8'd24) ? 8'hff : 8'(selAcc_reg * 8'd10 + digit);
          end else if (ch == `CH_SEMI) begin
            parse_next = PR_CNT;
          end
          cmdIssue_next = ch == `CH_FINAL;
        end
        PR_CNT: begin
          if (isDigit) begin
            parse_next = PR_CNT;
            cntAcc_next = (cntAcc_reg > `CNT_LIMIT) ? cntAcc_reg : 12'(cntAcc_reg * 12'd10 + 12'(digit));
          end
          cmdIssue_next = ch == `CH_FINAL;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      parse_reg <= PR_IDLE;
      selAcc_reg <= 8'h0;
      cntAcc_reg <= 12'h0;
      cmdIssue_reg <= 1'b0;
    end else begin
      parse_reg <= parse_next;
      selAcc_reg <= selAcc_next;
      cntAcc_reg <= cntAcc_next;
      cmdIssue_reg <= cmdIssue_next;
    end
  end

  logic [10:0] cmdMask;
  always_comb begin
    case (selAcc_reg)
      8'd0: cmdMask = `MASK_SEL0;
      8'd1: cmdMask = `MASK_SEL1;
      8'd2: cmdMask = 11'h001 << T_EIA;
      8'd3: cmdMask = 11'h001 << T_SPR;
      8'd6: cmdMask = 11'h001 << T_SIG;
      8'd7: cmdMask = 11'h001 << T_CLP;
      8'd20: cmdMask = 11'h001 << T_PPR;
      8'd21: cmdMask = 11'h001 << T_KBD;
      8'd22: cmdMask = 11'h001 << T_ROM;
      8'd23: cmdMask = 11'h001 << T_RAM;
      8'd24: cmdMask = 11'h001 << T_RFM;
      8'd25: cmdMask = 11'h001 << T_SET;
      8'd26: cmdMask = `MASK_DSP;
      default: cmdMask = 11'h000;
    endcase
  end

  // ==========================================================
  // Sequencer
  seq_state_t seq_reg;
  logic autoPending_reg;
  logic [10:0] mask_reg, passMask_reg;
  logic [33:0] timer_reg;
  logic [2:0] step_reg;
  logic [1:0] byteIdx_reg;
  logic [33:0] blinkCnt_reg;

  wire launch = (seq_reg == SQ_IDLE) & (autoPending_reg | (cmdIssue_reg & (cmdMask != 11'h0)));
  wire [8:0] launchLoops = autoPending_reg ? 9'd1 :
                           (cntAcc_reg > `CNT_LIMIT) ? `CNT_CLAMP : cntAcc_reg[8:0];
  wire launchForever = ~autoPending_reg & (cntAcc_reg == 12'h0);

  logic [3:0] nextId;
  always_comb begin
    nextId = 4'hf;
    for (int i = 10; i >= 0; i--) begin
      if (mask_reg[i]) nextId = 4'(i);
    end
  end
  wire anyLeft = mask_reg != 11'h0;
  wire repeatPass = forever_reg | (loops_reg > 9'd1);

  logic [4:0] curLine;
  always_comb begin
    case (status.test)
      T_RFM: curLine = `LINE_RFM;
      T_ROM: curLine = `LINE_ROM;
      T_KBD: curLine = `LINE_KBD;
      T_EIA: curLine = `LINE_EIA;
      T_SPR: curLine = `LINE_SPR;
      T_SIG: curLine = `LINE_SIG;
      T_PPR: curLine = `LINE_PPR;
      T_CLP: curLine = `LINE_CLP;
      T_SET: curLine = `LINE_SET;
      default: curLine = `LINE_NONE;
    endcase
  end

  // Control-line steps: 0 speed on, 1 speed off, 2 ready on, 3 ready off, 4 rts off, 5 rts on.
  logic sigBad;
  logic [2:0] sigCode;
  always_comb begin
    sigBad = 1'b0;
    sigCode = 3'd0;
    case (step_reg)
      3'd0: begin sigBad = ~speedIndIn; sigCode = 3'd0; end
      3'd1: begin sigBad = speedIndIn; sigCode = 3'd1; end
      3'd2: begin sigBad = ~dsr; sigCode = 3'd2; end
      3'd3: begin sigBad = dsr; sigCode = 3'd3; end
      3'd4: begin sigBad = cts | rlsd; sigCode = cts ? 3'd4 : 3'd5; end
      3'd5: begin sigBad = ~cts | ~rlsd; sigCode = ~cts ? 3'd6 : 3'd7; end
      default: ;
    endcase
  end
  wire [2:0] step_next = step_reg + 3'd1;
  wire settled = timer_reg >= SETTLE_CYC - 34'd1;

  logic failNow;
  logic [2:0] failCode;
  always_comb begin
    failNow = 1'b0;
    failCode = 3'd0;
    case (seq_reg)
      SQ_ENGINE: begin failNow = engineRsp.done & engineRsp.fail; failCode = engineRsp.code; end
      SQ_SIG: begin failNow = settled & sigBad; failCode = sigCode; end
      SQ_ACK: failNow = ~ackIn & (timer_reg >= ACK_CYC - 34'd1);
      SQ_BUSY: failNow = busyIn & (timer_reg >= BUSY_CYC - 34'd1);
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      blinkCnt_reg <= 34'h0;
    end else begin
      blinkCnt_reg <= (blinkCnt_reg >= BLINK_CYC - 34'd1) ? 34'h0 : blinkCnt_reg + 34'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq_reg <= SQ_IDLE;
      autoPending_reg <= 1'b1;
      mask_reg <= 11'h0;
      passMask_reg <= 11'h0;
      loops_reg <= 9'd0;
      forever_reg <= 1'b0;
      commanded_reg <= 1'b0;
      timer_reg <= 34'h0;
      step_reg <= 3'd0;
      byteIdx_reg <= 2'd0;
      engineReq <= '0;
      modemCtl <= '0;
      printerOut <= '0;
      status <= '0;
    end else begin
      engineReq.start <= 1'b0;
      status.bell <= 1'b0;
      timer_reg <= timer_reg + 34'd1;
      if (seq_reg == SQ_IDLE || blinkCnt_reg != 34'h0) begin
        status.blink <= status.running & commanded_reg & (status.blink | (seq_reg == SQ_IDLE));
      end else begin
        status.blink <= commanded_reg & ~status.blink;
      end
      if (failNow) begin
        seq_reg <= SQ_IDLE;
        status.running <= 1'b0;
        status.code <= failCode;
        status.line <= curLine;
        status.showErr <= (status.test != T_RAM) && (status.test != T_DSP);
        status.bell <= status.test == T_RAM;
        status.showEnd <= commanded_reg;
        status.blink <= 1'b0;
        modemCtl <= '0;
        printerOut <= '0;
      end else begin
        case (seq_reg)
          SQ_IDLE: if (launch) begin
            autoPending_reg <= 1'b0;
            mask_reg <= autoPending_reg ? `MASK_POWERON : cmdMask;
            passMask_reg <= autoPending_reg ? `MASK_POWERON : cmdMask;
            loops_reg <= launchLoops;
            forever_reg <= launchForever;
            commanded_reg <= ~autoPending_reg;
            status <= '0;
            status.running <= 1'b1;
            seq_reg <= SQ_PICK;
          end
          SQ_PICK: begin
            timer_reg <= 34'h0;
            if (anyLeft) begin
              mask_reg[nextId] <= 1'b0;
              status.test <= test_id_t'(nextId);
              step_reg <= 3'd0;
              byteIdx_reg <= 2'd0;
              if (nextId == T_SIG) begin
                modemCtl <= 3'b100;
                seq_reg <= SQ_SIG;
              end else if (nextId == T_PPR) begin
                printerOut <= {1'b1, 8'(`PRT_MSG >> 24)};
                seq_reg <= SQ_STB;
              end else begin
                engineReq <= {1'b1, test_id_t'(nextId)};
                seq_reg <= SQ_ENGINE;
              end
            end else if (repeatPass) begin
              mask_reg <= passMask_reg;
              if (!forever_reg) loops_reg <= loops_reg - 9'd1;
            end else begin
              seq_reg <= SQ_IDLE;
              status.running <= 1'b0;
              status.showOk <= passMask_reg != `MASK_DSP;
              loops_reg <= 9'd0;
            end
          end
          SQ_ENGINE: if (engineRsp.done) seq_reg <= SQ_PICK;
          SQ_SIG: if (settled) begin
            timer_reg <= 34'h0;
            step_reg <= step_next;
            case (step_reg)
              3'd0: modemCtl <= 3'b000;
              3'd1: modemCtl <= 3'b010;
              3'd2: modemCtl <= 3'b000;
              3'd3: modemCtl <= 3'b000;
              3'd4: modemCtl <= 3'b001;
              default: begin
                modemCtl <= 3'b000;
                seq_reg <= SQ_PICK;
              end
            endcase
          end
          SQ_STB: if (timer_reg >= STB_CYC - 34'd1) begin
            printerOut.strobe <= 1'b0;
            timer_reg <= 34'h0;
            seq_reg <= SQ_ACK;
          end
          SQ_ACK: if (ackIn) begin
            timer_reg <= 34'h0;
            seq_reg <= SQ_BUSY;
          end
          SQ_BUSY: if (!busyIn) begin
            timer_reg <= 34'h0;
            byteIdx_reg <= byteIdx_reg + 2'd1;
            if (byteIdx_reg == 2'd3) begin
              seq_reg <= SQ_PICK;
            end else begin
              printerOut <= {1'b1, 8'(`PRT_MSG >> (8'd16 - {byteIdx_reg, 3'b000}))};
              seq_reg <= SQ_STB;
            end
          end
          default: seq_reg <= SQ_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  power_on_run_a: assert property ($fell(sys_rst) |-> ##[1:2] status.running)
    else $error("power-on diagnosis did not start");
  power_on_order_a: assert property ($rose(status.running) && !commanded_reg
    |-> ##1 status.test == T_RAM)
    else $error("power-on diagnosis did not start with work memory");
  ram_bell_a: assert property (failNow && status.test == T_RAM
    |=> status.bell && !status.showErr)
    else $error("work memory failure did not ring the bell silently");
  err_line_a: assert property (seq_reg == SQ_ENGINE && failNow && status.test == T_RFM
    |=> status.line == 5'd2 && status.code == $past(engineRsp.code))
    else $error("screen memory error misreported");
  kbd_line_a: assert property (seq_reg == SQ_ENGINE && failNow && status.test == T_KBD
    |=> status.line == 5'd6 && status.showErr)
    else $error("keyboard error misreported");
  count_clamp_a: assert property (launch && !autoPending_reg && cntAcc_reg > 12'd256
    |=> loops_reg == 9'd255 && !forever_reg)
    else $error("repeat count not clamped");
  sel_single_a: assert property (launch && !autoPending_reg && selAcc_reg == 8'd20
    |-> ##2 status.test == T_PPR && seq_reg == SQ_STB)
    else $error("selector 20 did not start printer test");
  sel_combined_a: assert property (launch && !autoPending_reg && selAcc_reg == 8'd0
    |=> passMask_reg == 11'h1fc)
    else $error("selector 0 loaded wrong set");
  end_notice_a: assert property (failNow && commanded_reg |=> status.showEnd && !status.running)
    else $error("commanded failure without end notice");
  printer_line_a: assert property (seq_reg == SQ_ACK && failNow |=> status.line == 5'd14)
    else $error("printer timeout misreported");
  ctl_code_a: assert property (seq_reg == SQ_SIG && failNow && step_reg == 3'd0
    |=> status.code == 3'd0 && status.line == 5'd12)
    else $error("speed indicate error misreported");
  pattern_quiet_a: assert property (seq_reg == SQ_PICK && !anyLeft && !repeatPass
    && passMask_reg == 11'h400 |=> !status.showOk && !status.showErr)
    else $error("display pattern test showed a message");

  pass_cov: cover property (seq_reg == SQ_PICK && !anyLeft && !repeatPass);
  fail_cov: cover property (failNow && commanded_reg);
  repeat_cov: cover property (seq_reg == SQ_PICK && !anyLeft && repeatPass);
endmodule
`default_nettype wire

/* testbench/far_side_model.sv */
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire self_test_pkg::engine_req_t engineReq,
  output var self_test_pkg::engine_rsp_t engineRsp,
  input wire logic failEn,
  input wire self_test_pkg::test_id_t failId,
  input wire logic [2:0] failCode,
  input wire logic [3:0] lat,
  input wire self_test_pkg::modem_ctl_t modemCtl,
  output var self_test_pkg::modem_sense_t modemSense,
  input wire self_test_pkg::printer_out_t printerOut,
  output var logic printerAck,
  output var logic printerBusy
);
  import self_test_pkg::*;
  // ==========
  // Loop plug and printer.
  logic busyReg;
  logic [3:0] cntReg;
  test_id_t idReg;
  // The failure knob can also break the speed loop or hold back the printer acknowledge.
  wire cutSpeed = failEn && failId == T_SIG;
  assign modemSense = {modemCtl.speedSel & ~cutSpeed, modemCtl.termReady, modemCtl.reqSend, modemCtl.reqSend};
  always_ff @(posedge ref_clk) begin
    printerBusy <= printerOut.strobe & ~sys_rst;
    printerAck <= printerBusy & ~printerOut.strobe & ~(failEn && failId == T_PPR);
    engineRsp <= '0;
    if (sys_rst) begin
      busyReg <= 1'b0;
    end else if (engineReq.start) begin
      busyReg <= 1'b1;
      cntReg <= lat;
      idReg <= engineReq.id;
    end else if (busyReg && cntReg == 4'h0) begin
      busyReg <= 1'b0;
      engineRsp <= {1'b1, failEn && idReg == failId, failCode};
    end else if (busyReg) begin
      cntReg <= cntReg - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_terminal_self_test_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_terminal_self_test_sequencer;
  import self_test_pkg::*;
  // ==========
  // Signals and instances.
  logic ref_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, kbdValid, failEn;
  logic awready, wready, bvalid, arready, rvalid, printerAck, printerBusy;
  logic [3:0] awaddr, araddr, wstrb, lat;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] bresp, rresp;
  logic [7:0] kbdByte;
  logic [2:0] failCode;
  test_id_t failId;
  engine_req_t engineReq;
  engine_rsp_t engineRsp;
  modem_ctl_t modemCtl;
  modem_sense_t modemSense;
  printer_out_t printerOut;
  display_status_t status;
  int numErrors, compares, cyc, starts, bells, blinks, n;
  test_id_t idQ[$];
  logic [7:0] bq[$];
  int fs[9] = '{24, 22, 21, 3, 7, 25, 23, 6, 20};
  test_id_t fi[9] = '{T_RFM, T_ROM, T_KBD, T_SPR, T_CLP, T_SET, T_RAM, T_SIG, T_PPR};
  int fc[9] = '{1, 0, 1, 3, 2, 0, 0, 0, 0};
  int ln[9] = '{2, 4, 6, 10, 16, 2, 0, 12, 14};
  test_id_t single[6] = '{T_KBD, T_ROM, T_RAM, T_RFM, T_SET, T_DSP};
  terminal_self_test_sequencer #(.ACK_CYC(34'd200), .BUSY_CYC(34'd300), .BLINK_CYC(34'd16))
  u_terminal_self_test_sequencer (.ref_clk(ref_clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .kbdValid(kbdValid), .kbdByte(kbdByte),
    .engineReq(engineReq), .engineRsp(engineRsp), .modemCtl(modemCtl), .modemSense(modemSense),
    .printerOut(printerOut), .printerAck(printerAck), .printerBusy(printerBusy), .status(status));
  far_side_model u_far_side_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .engineReq(engineReq),
    .engineRsp(engineRsp), .failEn(failEn), .failId(failId), .failCode(failCode), .lat(lat),
    .modemCtl(modemCtl), .modemSense(modemSense), .printerOut(printerOut), .printerAck(printerAck),
    .printerBusy(printerBusy));
  // ==========
  // Helpers.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic void num(input int v);
    if (v >= 100) bq.push_back(8'(48 + v / 100));
    if (v >= 10) bq.push_back(8'(48 + (v / 10) % 10));
    bq.push_back(8'(48 + v % 10));
  endfunction
  task automatic printVerdict();
    if (numErrors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 0;
    chk("bresp", 2'b00, bresp);
  endtask
  task automatic axiRead(input logic [3:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rready <= 0;
  endtask
  task automatic run(input int sel, input int cnt, input bit host);
    idQ.delete();
    starts = 0;
    bells = 0;
    blinks = 0;
    bq = '{8'h1b, 8'h5b, 8'h34, 8'h3b};
    num(sel);
    bq.push_back(8'h3b);
    num(cnt);
    bq.push_back(8'h79);
    foreach (bq[k]) begin
      if (host) axiWrite(4'h0, {24'h0, bq[k]});
      else begin
        kbdValid <= 1;
        kbdByte <= bq[k];
        @(posedge ref_clk);
      end
    end
    kbdValid <= 0;
    repeat (8) @(posedge ref_clk);
    while (status.running !== 1'b0) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask
  // ==========
  // Clock, monitors and scenarios.
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (engineReq.start === 1'b1) begin
      starts++;
      idQ.push_back(engineReq.id);
    end
    if (status.bell === 1'b1) bells++;
    if (status.blink === 1'b1) blinks++;
    if (cyc == 60000) begin
      numErrors++;
      printVerdict();
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, kbdValid, failEn} = '0;
    {awaddr, araddr, wstrb, lat, wdata, kbdByte, failCode} = '0;
    {numErrors, compares, cyc, starts, bells, blinks} = '0;
    failId = T_RAM;
    seed = 32'd31320;
    sys_rst = 1;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 0;
    repeat (8) @(posedge ref_clk);
    while (status.running !== 1'b0) @(posedge ref_clk);
    chk("poweron order", {T_RAM, T_RFM, T_ROM, T_KBD}, {idQ[0], idQ[1], idQ[2], idQ[3]});
    chk("poweron ok", 1, status.showOk);
    chk("no blink", 0, blinks);
    failEn <= 1;
    for (int i = 0; i < 9; i++) begin
      failId <= fi[i];
      failCode <= 3'(fc[i]);
      run(fs[i], 1, 0);
      chk("fail line", ln[i], status.line);
      if (ln[i] != 0) chk("fail code", fc[i], status.code);
      chk("error shown", ln[i] != 0, status.showErr);
      chk("end shown", 1, status.showEnd);
      chk("bell", ln[i] == 0, bells);
    end
    failId <= T_EIA;
    failCode <= 3'd2;
    run(0, 1, 1);
    chk("combined order", {T_ROM, T_KBD, T_EIA}, {idQ[0], idQ[1], idQ[2]});
    axiRead(4'h4);
    chk("status reg", {1'b0, T_EIA, 3'd2, 5'd8}, rdata[19:7]);
    axiRead(4'hc);
    chk("unmapped", 2'b10, rresp);
    failEn <= 0;
    run(6, 1, 0);
    chk("lines ok", 1, status.showOk);
    chk("blink", 1, blinks > 0);
    run(1, 1, 0);
    chk("sel one", {T_RFM, T_ROM, T_KBD}, {idQ[0], idQ[1], idQ[2]});
    run(2, 1, 0);
    chk("sel two", T_EIA, idQ[0]);
    for (int s = 20; s <= 26; s++) begin
      seed = xs(seed);
      lat <= seed[3:0];
      n = 1 + seed[4];
      run(s, n, 0);
      chk("runs", (s == 20) ? 0 : n, starts);
      chk("ok shown", s != 26, status.showOk);
      if (s != 20) chk("test id", single[s - 21], idQ[0]);
    end
    lat <= 4'h0;
    run(22, 300, 0);
    chk("clamped runs", 255, starts);
    printVerdict();
  end
endmodule
`default_nettype wire
